// file: hdl/pin_function_switch_matrix.sv
`timescale 1ns/1ps
`include "pin_mux_params.svh"
module pin_function_switch_matrix
    import pin_mux_pkg::*;
#(
    parameter int N_PADS = `N_PADS_DEF,
    parameter int N_MOV = `N_MOV_DEF,
    parameter int N_TMR = `N_TMR_DEF,
    // Candidate pads per timer signal, three per channel; 6'h3F is no pad.
    parameter logic [N_TMR*3*`PAD_W-1:0] TMR_PADS = {6'h1B, 6'h24, 6'h14, 6'h22, 6'h23, 6'h13,
        6'h10, 6'h22, 6'h12, 6'h3F, 6'h21, 6'h11}
) (
    input wire logic clk_sys_i,
    input wire logic rst_n_i,
    input wire logic ce_i,
    input wire logic cfg_wr_i,
    input wire logic [`PAD_W-1:0] cfg_pad_i,
    input wire pad_mode_t cfg_mode_i,
    input wire logic [`FUNC_W-1:0] cfg_func_i,
    input wire logic tmr_wr_i,
    input wire logic [1:0] tmr_ch_i,
    input wire logic [1:0] tmr_sel_i,
    input wire logic [N_PADS-1:0] pad_in_i,
    output logic [N_PADS-1:0] pad_out_o,
    output logic [N_PADS-1:0] pad_oe_n_o,
    output logic [N_PADS-1:0] analog_en_o,
    input wire logic [N_PADS-1:0] gpio_out_i,
    input wire logic [N_PADS-1:0] gpio_oe_i,
    output logic [N_PADS-1:0] gpio_in_o,
    input wire logic [N_PADS-1:0] fixed_out_i,
    input wire logic [N_PADS-1:0] fixed_oe_i,
    output logic [N_PADS-1:0] fixed_in_o,
    input wire logic [N_MOV-1:0] mov_out_i,
    input wire logic [N_MOV-1:0] mov_oe_i,
    output logic [N_MOV-1:0] mov_in_o,
    input wire logic [N_TMR-1:0] tmr_out_i,
    input wire logic [N_TMR-1:0] tmr_oe_i,
    output logic [N_TMR-1:0] tmr_in_o,
    input wire logic bscan_i,
    input wire logic tap_tdo_i,
    output logic tap_tdi_o,
    output logic tap_tms_o,
    output logic tap_tck_o,
    output logic tap_trst_n_o,
    input wire logic dpd_i,
    output logic dpd_wake_o,
    output logic ext_reset_o,
    output logic isp_mode_o,
    input wire logic uart0_tx_i,
    output logic uart0_rx_o,
    input wire logic wkt_ext_sel_i,
    output logic wkt_clk_o,
    input wire logic [1:0] fmp_i,
    output logic [1:0] high_sink_o
);
    localparam int WAKE_CYC = (`WAKE_MIN_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS;
    localparam int RST_CYC = (`RESET_MIN_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS;

    ////////////////////////////////////////////////////////////////////////////////
    // Configuration state.
    pad_mode_t mode_r [N_PADS];  // Function class of each pad.
    pad_mode_t mode_nxt [N_PADS];
    logic [`FUNC_W-1:0] func_r [N_PADS];  // Movable function index per pad.
    logic [`FUNC_W-1:0] func_nxt [N_PADS];
    logic [1:0] tsel_r [N_TMR];  // Candidate choice per timer signal.
    logic [1:0] tsel_nxt [N_TMR];

    // Writes land on one pad or one timer signal; reset gives debug and reset pads.
    always_comb begin
        for (int p = 0; p < N_PADS; p++) begin
            mode_nxt[p] = mode_r[p];
            func_nxt[p] = func_r[p];
            if (!rst_n_i) begin
                mode_nxt[p] = MODE_GPIO;
                func_nxt[p] = '0;
                if (p == `PAD_TMS || p == `PAD_TCK || p == `PAD_RESET) begin
                    mode_nxt[p] = MODE_FIXED;
                end
            end else if (cfg_wr_i && cfg_pad_i == p[`PAD_W-1:0]) begin
                mode_nxt[p] = cfg_mode_i;
                func_nxt[p] = cfg_func_i;
            end
        end
        for (int c = 0; c < N_TMR; c++) begin
            tsel_nxt[c] = tsel_r[c];
            if (!rst_n_i) begin
                tsel_nxt[c] = `TMR_NC;
            end else if (tmr_wr_i && tmr_ch_i == c[1:0]) begin
                tsel_nxt[c] = tmr_sel_i;
            end
        end
    end

    // The clock enable freezes every register of the block.
    always_ff @(posedge clk_sys_i) begin
        if (ce_i) begin
            mode_r <= mode_nxt;
            func_r <= func_nxt;
            tsel_r <= tsel_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Pad and scan-strap synchronisers; only the second stage is ever read.
    logic [N_PADS:0] sync_m_r;
    logic [N_PADS:0] sync_s_r;
    logic [N_PADS:0] sync_m_nxt;
    logic [N_PADS:0] sync_s_nxt;
    logic [N_PADS-1:0] pad_s;
    logic bscan_s;
    assign pad_s = sync_s_r[N_PADS-1:0];
    assign bscan_s = sync_s_r[N_PADS];

    // Idle pads read high so that reset and wake counters start quiet.
    always_comb begin
        sync_m_nxt = rst_n_i ? {bscan_i, pad_in_i} : {1'h0, {N_PADS{1'h1}}};
        sync_s_nxt = rst_n_i ? sync_m_r : {1'h0, {N_PADS{1'h1}}};
    end

    always_ff @(posedge clk_sys_i) begin
        if (ce_i) begin
            sync_m_r <= sync_m_nxt;
            sync_s_r <= sync_s_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Pad multiplexer; the result is registered once so each pin leaves a flop.
    logic [N_PADS-1:0] out_nxt, oen_nxt, ana_nxt, gin_nxt, fin_nxt;
    logic [N_MOV-1:0] min_nxt;
    logic [N_TMR-1:0] tin_nxt;
    logic [3:0] tap_nxt;
    logic [`PAD_W-1:0] cand;
    logic [`PAD_W-1:0] tpad [N_TMR];

    // Chosen pad of each timer signal, or none.
    always_comb begin
        for (int c = 0; c < N_TMR; c++) begin
            tpad[c] = '1;
            if (tsel_r[c] != `TMR_NC) begin
                tpad[c] = TMR_PADS[(c*3+int'(tsel_r[c]))*`PAD_W +: `PAD_W];
            end
        end
    end

    // Priority: scan, programming UART, timer, then the pad's own selection.
    always_comb begin
        cand = '0;
        min_nxt = '0;
        tin_nxt = '0;
        for (int p = 0; p < N_PADS; p++) begin
            out_nxt[p] = 1'h0;
            oen_nxt[p] = 1'h1;
            ana_nxt[p] = 1'h0;
            gin_nxt[p] = 1'h0;
            fin_nxt[p] = 1'h0;
            if (bscan_s && p <= `PAD_TRST) begin
                // Only test-data-out drives; the other four are inputs.
                out_nxt[p] = (p == `PAD_TDO) ? tap_tdo_i : 1'h0;
                oen_nxt[p] = (p != `PAD_TDO);
            end else if (isp_mode_o && p == `PAD_UTX) begin
                out_nxt[p] = uart0_tx_i;
                oen_nxt[p] = 1'h0;
            end else begin
                case (mode_r[p])
                    MODE_GPIO: begin
                        out_nxt[p] = gpio_out_i[p];
                        oen_nxt[p] = !gpio_oe_i[p];
                        gin_nxt[p] = pad_s[p];
                    end
                    MODE_FIXED: begin
                        out_nxt[p] = fixed_out_i[p];
                        oen_nxt[p] = !fixed_oe_i[p];
                        fin_nxt[p] = pad_s[p];
                    end
                    MODE_MOVABLE: begin
                        // Any index on any pad; indexes past the last function stay idle.
                        if (int'(func_r[p]) < N_MOV) begin
                            out_nxt[p] = mov_out_i[func_r[p]];
                            oen_nxt[p] = !mov_oe_i[func_r[p]];
                            min_nxt[func_r[p]] = min_nxt[func_r[p]] | pad_s[p];
                        end
                    end
                    default: begin
                        ana_nxt[p] = 1'h1;
                    end
                endcase
                for (int c = 0; c < N_TMR; c++) begin
                    if (tpad[c] == p[`PAD_W-1:0]) begin
                        gin_nxt[p] = 1'h0;
                        if (tmr_oe_i[c]) begin
                            out_nxt[p] = tmr_out_i[c];
                            oen_nxt[p] = 1'h0;
                        end
                    end
                end
            end
            // True open-drain pads never drive high.
            if (p == `PAD_ODR10 || p == `PAD_ODR11) begin
                oen_nxt[p] = oen_nxt[p] | out_nxt[p];
                out_nxt[p] = 1'h0;
            end
        end
        for (int c = 0; c < N_TMR; c++) begin
            if (int'(tpad[c]) < N_PADS) begin
                cand = tpad[c];
                tin_nxt[c] = pad_s[cand];
            end
        end
        tap_nxt = bscan_s ? {pad_s[`PAD_TDI], pad_s[`PAD_TMS], pad_s[`PAD_TCK],
            pad_s[`PAD_TRST]} : 4'h1;
        if (!rst_n_i) begin
            out_nxt = '0;
            oen_nxt = '1;
            ana_nxt = '0;
            gin_nxt = '0;
            fin_nxt = '0;
            min_nxt = '0;
            tin_nxt = '0;
            tap_nxt = 4'h1;
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (ce_i) begin
            pad_out_o <= out_nxt;
            pad_oe_n_o <= oen_nxt;
            analog_en_o <= ana_nxt;
            gpio_in_o <= gin_nxt;
            fixed_in_o <= fin_nxt;
            mov_in_o <= min_nxt;
            tmr_in_o <= tin_nxt;
            {tap_tdi_o, tap_tms_o, tap_tck_o, tap_trst_n_o} <= tap_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Wake, external reset, boot strap and side signals.
    logic [3:0] wake_cnt_r, wake_cnt_nxt;
    logic [3:0] rst_cnt_r, rst_cnt_nxt;
    logic [1:0] boot_cnt_r, boot_cnt_nxt;
    logic wake_nxt, xrst_nxt, isp_nxt, urx_nxt, wclk_nxt;
    logic [1:0] sink_nxt;
    logic wake_hit, rst_hit;

    // A pad low for the full count of samples makes a one-cycle event.
    assign wake_hit = !pad_s[`PAD_WAKE] && wake_cnt_r == 4'(WAKE_CYC - 1);
    assign rst_hit = !pad_s[`PAD_RESET] && rst_cnt_r == 4'(RST_CYC - 1);

    always_comb begin
        wake_cnt_nxt = 4'h0;
        rst_cnt_nxt = 4'h0;
        // Wake counting starts in deep power-down with the pad kept free of movable use.
        if (dpd_i && mode_r[`PAD_WAKE] != MODE_MOVABLE && !pad_s[`PAD_WAKE]) begin
            // Counts park one past the hit so a held pad fires only once.
            wake_cnt_nxt = (wake_cnt_r == 4'(WAKE_CYC)) ? wake_cnt_r : wake_cnt_r + 4'h1;
        end
        if (mode_r[`PAD_RESET] == MODE_FIXED && !pad_s[`PAD_RESET]) begin
            rst_cnt_nxt = (rst_cnt_r == 4'(RST_CYC)) ? rst_cnt_r : rst_cnt_r + 4'h1;
        end
        // Events fire only on the count's first arrival, not while held.
        wake_nxt = dpd_i && mode_r[`PAD_WAKE] != MODE_MOVABLE && wake_hit;
        wake_nxt = wake_nxt || (dpd_i && mode_r[`PAD_RESET] == MODE_FIXED && rst_hit);
        xrst_nxt = mode_r[`PAD_RESET] == MODE_FIXED && rst_hit;
        // Strap is caught once the second synchroniser stage holds live pad data.
        boot_cnt_nxt = (boot_cnt_r == `BOOT_SAMPLE_CYC + 2'h1) ? boot_cnt_r : boot_cnt_r + 2'h1;
        isp_nxt = isp_mode_o;
        if (boot_cnt_r == `BOOT_SAMPLE_CYC) begin
            isp_nxt = !pad_s[`PAD_BOOT];
        end
        urx_nxt = isp_mode_o ? pad_s[`PAD_URX] : 1'h1;
        // Not gated by power mode, so the timer keeps its clock in power-down.
        wclk_nxt = wkt_ext_sel_i && pad_s[`PAD_WCLK];
        sink_nxt = fmp_i;
        if (!rst_n_i) begin
            wake_cnt_nxt = 4'h0;
            rst_cnt_nxt = 4'h0;
            boot_cnt_nxt = 2'h0;
            wake_nxt = 1'h0;
            xrst_nxt = 1'h0;
            isp_nxt = 1'h0;
            urx_nxt = 1'h1;
            wclk_nxt = 1'h0;
            sink_nxt = 2'h0;
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (ce_i) begin
            wake_cnt_r <= wake_cnt_nxt;
            rst_cnt_r <= rst_cnt_nxt;
            boot_cnt_r <= boot_cnt_nxt;
            dpd_wake_o <= wake_nxt;
            ext_reset_o <= xrst_nxt;
            isp_mode_o <= isp_nxt;
            uart0_rx_o <= urx_nxt;
            wkt_clk_o <= wclk_nxt;
            high_sink_o <= sink_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Checks.
    chk_reset_pads_idle: assert property (@(posedge clk_sys_i) (!rst_n_i && ce_i) |=>
        (&pad_oe_n_o && gpio_in_o == '0)) else $error("pads drive after reset");
    chk_debug_default_pads: assert property (@(posedge clk_sys_i) (!rst_n_i && ce_i) |=>
        (mode_r[`PAD_TMS] == MODE_FIXED && mode_r[`PAD_TCK] == MODE_FIXED))
        else $error("debug pads not fixed after reset");
    chk_scan_tdo_drive: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        (ce_i && bscan_s) |=> (!pad_oe_n_o[`PAD_TDO] && pad_out_o[`PAD_TDO] == $past(tap_tdo_i)))
        else $error("scan does not drive test data out");
    chk_gpio_off_assigned: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        (ce_i && mode_r[7] != MODE_GPIO) |=> !gpio_in_o[7]) else $error("gpio input live");
    chk_analog_cuts_digital: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        (ce_i && mode_r[13] == MODE_ANALOG) |=> (pad_oe_n_o[13] && analog_en_o[13]))
        else $error("analog pad still digital");
    chk_wake_low_time: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        ($rose(dpd_wake_o) && ce_i && !$past(rst_hit)) |-> ($past(!pad_s[`PAD_WAKE], 1)
        && $past(!pad_s[`PAD_WAKE], 5))) else $error("wake without 50 ns low");
    chk_ext_reset_pulse: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        $rose(ext_reset_o) |-> ($past(!pad_s[`PAD_RESET], 1) && $past(!pad_s[`PAD_RESET], 2)))
        else $error("reset event without 20 ns low");
    chk_isp_uart_tx: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        (ce_i && isp_mode_o && !bscan_s) |=> (!pad_oe_n_o[`PAD_UTX]
        && pad_out_o[`PAD_UTX] == $past(uart0_tx_i))) else $error("uart transmit not on pad");
    chk_fmp_sink_only: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        (ce_i && !fmp_i[0]) |=> !high_sink_o[0]) else $error("high sink without fast plus");
endmodule

// file: hdl/pin_mux_params.svh
`ifndef PIN_MUX_PARAMS_SVH
`define PIN_MUX_PARAMS_SVH
// Pad counts and the pads with a dedicated duty.
`define N_PADS_DEF 54
`define N_MOV_DEF 20
`define N_TMR_DEF 4
`define PAD_W 6
`define FUNC_W 5
`define PAD_TDO 0
`define PAD_TDI 1
`define PAD_TMS 2
`define PAD_TCK 3
`define PAD_TRST 4
`define PAD_WAKE 4
`define PAD_RESET 5
`define PAD_ODR10 10
`define PAD_ODR11 11
`define PAD_BOOT 12
`define PAD_URX 24
`define PAD_UTX 25
`define PAD_WCLK 28
`define TMR_NC 2'h3
// Timing in nanoseconds, the clock period, and the boot strap sample point in cycles.
`define CLK_PERIOD_NS 10
`define WAKE_MIN_NS 50
`define RESET_MIN_NS 20
`define BOOT_SAMPLE_CYC 2'h2
`endif

// file: hdl/pin_mux_pkg.sv
package pin_mux_pkg;
    // Function that a pad carries.
    typedef enum logic [1:0] {MODE_GPIO, MODE_FIXED, MODE_MOVABLE, MODE_ANALOG} pad_mode_t;
endpackage

// file: tb/pad_env_model.sv
`timescale 1ns/1ps
//////////////////////////////////////////////////////////////////////
// Board and pads around the matrix: chip drive wins, then the bench's
// board drive, then a pull-up where fitted, else a toggling level.
module pad_env_model #(
    parameter int N_PADS = 54,
    // Wake, reset, boot and the two open-drain pads carry pull-ups.
    parameter logic [53:0] PULL_MASK = 54'h1C30
) (
    input wire logic clk_sys_i,
    input wire logic [N_PADS-1:0] pad_out_i,
    input wire logic [N_PADS-1:0] pad_oe_n_i,
    input wire logic [N_PADS-1:0] ext_val_i,
    input wire logic [N_PADS-1:0] ext_en_i,
    output logic [N_PADS-1:0] pad_in_o
);
    logic flip_r = 1'h0; // Stand-in for a floating line.
    logic flip_nxt;
    // A floating pad must not look like a stable level, so it toggles.
    always_comb begin
        flip_nxt = ~flip_r;
    end
    always_ff @(posedge clk_sys_i) begin
        flip_r <= flip_nxt;
    end
    // Resolve each pad level from all parties that may drive it.
    always_comb begin
        for (int i = 0; i < N_PADS; i++) begin
            if (!pad_oe_n_i[i]) begin
                pad_in_o[i] = pad_out_i[i];
            end else if (ext_en_i[i]) begin
                pad_in_o[i] = ext_val_i[i];
            end else if (PULL_MASK[i]) begin
                pad_in_o[i] = 1'h1;
            end else begin
                pad_in_o[i] = flip_r;
            end
        end
    end
endmodule

// file: tb/pin_function_switch_matrix_tb.sv
`timescale 1ns/1ps
`include "pin_mux_params.svh"
module pin_function_switch_matrix_tb;
    import pin_mux_pkg::*;
    localparam int NP = 54;
    // Timer candidate pads, three per channel, channel 0 lowest.
    localparam logic [71:0] TMR_MAP = {6'h1B, 6'h24, 6'h14, 6'h22, 6'h23, 6'h13,
        6'h10, 6'h22, 6'h12, 6'h3F, 6'h21, 6'h11};
    logic clk_sys_i = 1'h0;
    logic rst_n_i = 1'h0;
    logic ce_i = 1'h1, cfg_wr_i = 1'h0, tmr_wr_i = 1'h0;
    logic [`PAD_W-1:0] cfg_pad_i = '0;
    pad_mode_t cfg_mode_i = MODE_GPIO;
    logic [`FUNC_W-1:0] cfg_func_i = '0;
    logic [1:0] tmr_ch_i = '0, tmr_sel_i = '0, fmp_i = '0, high_sink_o;
    logic [NP-1:0] pad_in_i, pad_out_o, pad_oe_n_o, analog_en_o, gpio_in_o, fixed_in_o;
    logic [NP-1:0] gpio_out_i = '0, gpio_oe_i = '0, fixed_out_i = '0, fixed_oe_i = '0;
    logic [NP-1:0] ext_val = '0, ext_en = '0; // Board drive onto the pads.
    logic [19:0] mov_out_i = '0, mov_oe_i = '0, mov_in_o;
    logic [3:0] tmr_out_i = '0, tmr_oe_i = '0, tmr_in_o;
    logic bscan_i = 1'h0, tap_tdo_i = 1'h0, dpd_i = 1'h0, uart0_tx_i = 1'h1, wkt_ext_sel_i = 1'h0;
    logic tap_tdi_o, tap_tms_o, tap_tck_o, tap_trst_n_o, dpd_wake_o, ext_reset_o;
    logic isp_mode_o, uart0_rx_o, wkt_clk_o;
    int n_errors = 0, num_checks = 0, nw, nr, p;
    always #5 clk_sys_i = ~clk_sys_i;
    pin_function_switch_matrix #(.TMR_PADS(TMR_MAP)) DUT (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i),
        .ce_i(ce_i), .cfg_wr_i(cfg_wr_i), .cfg_pad_i(cfg_pad_i), .cfg_mode_i(cfg_mode_i),
        .cfg_func_i(cfg_func_i), .tmr_wr_i(tmr_wr_i), .tmr_ch_i(tmr_ch_i), .tmr_sel_i(tmr_sel_i),
        .pad_in_i(pad_in_i), .pad_out_o(pad_out_o), .pad_oe_n_o(pad_oe_n_o),
        .analog_en_o(analog_en_o), .gpio_out_i(gpio_out_i), .gpio_oe_i(gpio_oe_i),
        .gpio_in_o(gpio_in_o), .fixed_out_i(fixed_out_i), .fixed_oe_i(fixed_oe_i),
        .fixed_in_o(fixed_in_o), .mov_out_i(mov_out_i), .mov_oe_i(mov_oe_i), .mov_in_o(mov_in_o),
        .tmr_out_i(tmr_out_i), .tmr_oe_i(tmr_oe_i), .tmr_in_o(tmr_in_o), .bscan_i(bscan_i),
        .tap_tdo_i(tap_tdo_i), .tap_tdi_o(tap_tdi_o), .tap_tms_o(tap_tms_o),
        .tap_tck_o(tap_tck_o), .tap_trst_n_o(tap_trst_n_o), .dpd_i(dpd_i),
        .dpd_wake_o(dpd_wake_o), .ext_reset_o(ext_reset_o), .isp_mode_o(isp_mode_o),
        .uart0_tx_i(uart0_tx_i), .uart0_rx_o(uart0_rx_o), .wkt_ext_sel_i(wkt_ext_sel_i),
        .wkt_clk_o(wkt_clk_o), .fmp_i(fmp_i), .high_sink_o(high_sink_o));
    pad_env_model env (.clk_sys_i(clk_sys_i), .pad_out_i(pad_out_o), .pad_oe_n_i(pad_oe_n_o),
        .ext_val_i(ext_val), .ext_en_i(ext_en), .pad_in_o(pad_in_i));
    //////////////////////////////////////////////////////////////////////
    // Compare one value and count it.
    task automatic chk(input string what, input logic [63:0] exp, input logic [63:0] got);
        num_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("unexpected %s: expected %0h, seen %0h", what, exp, got);
        end
    endtask
    // Let n edges pass, then step off the edge so outputs have settled.
    task automatic tick(input int n);
        repeat (n) @(posedge clk_sys_i);
        #1;
    endtask
    // One configuration write; outputs follow one edge after it is taken.
    task automatic cfg(input int pad, input pad_mode_t m, input int f);
        @(posedge clk_sys_i);
        cfg_wr_i <= 1'h1;
        cfg_pad_i <= `PAD_W'(pad);
        cfg_mode_i <= m;
        cfg_func_i <= `FUNC_W'(f);
        @(posedge clk_sys_i);
        cfg_wr_i <= 1'h0;
        tick(2);
    endtask
    // Pick a candidate pad for one timer signal.
    task automatic tsel(input int ch, input int sel);
        @(posedge clk_sys_i);
        tmr_wr_i <= 1'h1;
        tmr_ch_i <= 2'(ch);
        tmr_sel_i <= 2'(sel);
        @(posedge clk_sys_i);
        tmr_wr_i <= 1'h0;
        tick(2);
    endtask
    // Pull a pad low for len cycles and count the wake and reset pulses.
    task automatic low_pulse(input int pad, input int len);
        nw = 0;
        nr = 0;
        @(posedge clk_sys_i);
        ext_en[pad] <= 1'h1;
        ext_val[pad] <= 1'h0;
        for (int i = 0; i < 16; i++) begin
            @(posedge clk_sys_i);
            if (i == len - 1) begin
                ext_en[pad] <= 1'h0;
            end
            #1;
            nw += int'(dpd_wake_o === 1'h1);
            nr += int'(ext_reset_o === 1'h1);
        end
    endtask
    task automatic final_report();
        $display("checks %0d, mismatches %0d", num_checks, n_errors);
        if (n_errors == 0 && num_checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    // Bounded wait for pad 0 to change hands; running out ends the run as a failure.
    task automatic wait_tdo_oe(input logic v);
        for (int i = 0; i < 10 && pad_oe_n_o[0] !== v; i++) tick(1);
        if (pad_oe_n_o[0] !== v) begin
            n_errors++;
            final_report();
        end
    endtask
    // A hang counts as a mismatch and still reaches the report.
    initial begin
        #200000;
        n_errors++;
        final_report();
    end
    //////////////////////////////////////////////////////////////////////
    initial begin
        repeat (4) @(posedge clk_sys_i);
        rst_n_i <= 1'h1;
        tick(3);
        chk("pad_oe_n_o", {NP{1'h1}}, pad_oe_n_o);
        chk("tap_trst_n_o", 1'h1, tap_trst_n_o);
        chk("isp_mode_o", 1'h0, isp_mode_o);
        @(posedge clk_sys_i);
        fixed_oe_i[2] <= 1'h1;
        fixed_out_i[2] <= 1'h1;
        ext_en[3] <= 1'h1;
        ext_val[3] <= 1'h1;
        gpio_oe_i[7] <= 1'h1;
        gpio_out_i[7] <= 1'h1;
        mov_oe_i[3] <= 1'h1;
        tick(3);
        chk("pad_out_o[2]", 2'h1, {pad_oe_n_o[2], pad_out_o[2]});
        chk("fixed_in_o[3]", 2'h1, {gpio_in_o[3], fixed_in_o[3]});
        chk("pad_out_o[7]", 2'h1, {pad_oe_n_o[7], pad_out_o[7]});
        // With the clock enable low the registered pad drive must not follow.
        @(posedge clk_sys_i);
        ce_i <= 1'h0;
        gpio_out_i[7] <= 1'h0;
        tick(3);
        chk("frozen pad_out_o[7]", 1'h1, pad_out_o[7]);
        @(posedge clk_sys_i);
        ce_i <= 1'h1;
        gpio_out_i[7] <= 1'h1;
        tick(2);
        $display("test defaults done");
        // A movable output replaces the GPIO drive; one output can drive several pads.
        cfg(7, MODE_MOVABLE, 3);
        chk("pad_out_o[7]", 2'h0, {pad_oe_n_o[7], pad_out_o[7]});
        @(posedge clk_sys_i);
        mov_oe_i[19] <= 1'h1;
        mov_out_i[19] <= 1'h1;
        ext_en[20] <= 1'h1;
        ext_val[20] <= 1'h1;
        for (int k = 0; k < 3; k++) begin
            p = (k == 0) ? 9 : (k == 1) ? 31 : 53;
            cfg(p, MODE_MOVABLE, 19);
            chk("pad_out_o[p]", 2'h1, {pad_oe_n_o[p], pad_out_o[p]});
        end
        cfg(20, MODE_MOVABLE, 4);
        tick(3);
        chk("mov_in_o[4]", 2'h1, {gpio_in_o[20], mov_in_o[4]});
        @(posedge clk_sys_i);
        gpio_oe_i[13] <= 1'h1;
        fixed_oe_i[8] <= 1'h1;
        fixed_out_i[8] <= 1'h1;
        cfg(13, MODE_ANALOG, 0);
        chk("analog pad13", 2'h3, {analog_en_o[13], pad_oe_n_o[13]});
        cfg(8, MODE_FIXED, 0);
        chk("pad_out_o[8]", 2'h1, {pad_oe_n_o[8], pad_out_o[8]});
        $display("test assignment done");
        // Walk every candidate of timer signal 1, then disconnect it.
        @(posedge clk_sys_i);
        tmr_oe_i[1] <= 1'h1;
        tmr_out_i[1] <= 1'h1;
        for (int k = 0; k < 3; k++) begin
            p = int'(TMR_MAP[(3 + k) * 6 +: 6]);
            tsel(1, k);
            chk("timer pad", 2'h1, {pad_oe_n_o[p], pad_out_o[p]});
            tick(2);
            chk("tmr_in_o[1]", 1'h1, tmr_in_o[1]);
        end
        tsel(1, 3);
        chk("timer released", 1'h1, pad_oe_n_o[p]);
        chk("tmr_in_o[1] idle", 1'h0, tmr_in_o[1]);
        $display("test timer done");
        @(posedge clk_sys_i);
        bscan_i <= 1'h1;
        tap_tdo_i <= 1'h1;
        ext_en[1] <= 1'h1;
        ext_val[1] <= 1'h1;
        ext_en[2] <= 1'h1;
        ext_val[2] <= 1'h1;
        ext_val[3] <= 1'h0;
        wait_tdo_oe(1'h0);
        tick(3);
        chk("scan pads", 3'h3, {pad_oe_n_o[0], pad_out_o[0], tap_tdi_o});
        chk("scan tms tck", 2'h2, {tap_tms_o, tap_tck_o});
        @(posedge clk_sys_i);
        bscan_i <= 1'h0;
        wait_tdo_oe(1'h1);
        tick(1);
        chk("scan off", 2'h1, {tap_tdi_o, tap_trst_n_o});
        $display("test scan done");
        @(posedge clk_sys_i);
        dpd_i <= 1'h1;
        low_pulse(`PAD_WAKE, 4);
        chk("wake 40 ns", 0, nw);
        low_pulse(`PAD_WAKE, 6);
        chk("wake 60 ns", 1, nw);
        low_pulse(`PAD_RESET, 1);
        chk("reset 10 ns", 0, nr);
        low_pulse(`PAD_RESET, 2);
        chk("reset 20 ns", 2'h3, {nr == 1, nw == 1});
        @(posedge clk_sys_i);
        dpd_i <= 1'h0;
        $display("test wake done");
        @(posedge clk_sys_i);
        wkt_ext_sel_i <= 1'h1;
        fmp_i <= 2'h2;
        ext_en[`PAD_WCLK] <= 1'h1;
        for (int v = 0; v < 4; v++) begin
            ext_val[`PAD_WCLK] <= v[0];
            tick(3);
            chk("wkt_clk_o", v[0], wkt_clk_o);
            @(posedge clk_sys_i);
        end
        chk("high_sink_o", 2'h2, high_sink_o);
        $display("test clock and sink done");
        // Boot strap low through a second reset enters programming mode.
        rst_n_i <= 1'h0;
        ext_en[`PAD_BOOT] <= 1'h1;
        ext_val[`PAD_BOOT] <= 1'h0;
        repeat (4) @(posedge clk_sys_i);
        rst_n_i <= 1'h1;
        tick(4);
        chk("isp_mode_o", 1'h1, isp_mode_o);
        chk("analog_en_o", 0, analog_en_o);
        @(posedge clk_sys_i);
        uart0_tx_i <= 1'h0;
        ext_en[`PAD_URX] <= 1'h1;
        ext_val[`PAD_URX] <= 1'h0;
        tick(3);
        chk("uart pads", 3'h0, {pad_oe_n_o[25], pad_out_o[25], uart0_rx_o});
        $display("test boot done");
        final_report();
    end
endmodule
